// [src/bin_to_dec.sv]
// serial binary to packed decimal converter, one bit per clock
`include "span_ref_regs.svh"
`default_nettype none
module bin_to_dec (
   input wire logic mclk,
   input wire logic srst,
   input wire logic start,
   input wire logic [31:0] bin,
   output logic done,
   output logic [39:0] bcd
);
   logic [31:0] sh_q;
   logic [39:0] bcd_q;
   logic [5:0] cnt_q;
   logic busy_q;
   logic done_q;
   logic [39:0] adj;

   // add three to each digit of five or more before shifting
   always_comb begin
      adj = bcd_q;
      for (int i = 0; i < 10; i++) begin
         if (bcd_q[i*4 +: 4] > 4'h4) begin
            adj[i*4 +: 4] = bcd_q[i*4 +: 4] + 4'h3;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         sh_q <= 32'h00000000;
         bcd_q <= 40'h0000000000;
         cnt_q <= 6'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            sh_q <= bin;
            bcd_q <= 40'h0000000000;
            cnt_q <= 6'h00;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            bcd_q <= {adj[38:0], sh_q[31]};
            sh_q <= {sh_q[30:0], 1'b0};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == `CONV_BITS - 6'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   assign done = done_q;
   assign bcd = bcd_q;
endmodule
`default_nettype wire

// [src/span_and_ref_level_cmd_handler.sv]
// command interpreter for frequency span and reference level over the bus byte stream
`include "span_ref_regs.svh"
`default_nettype none
module span_and_ref_level_cmd_handler (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [4:0] addr_switch,
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   output logic rx_ready,
   output logic [7:0] tx_byte,
   output logic tx_valid,
   output logic tx_last,
   input wire logic tx_ready,
   input wire logic [5:0] atten_db,
   output logic [4:0] bus_addr,
   output logic [3:0] span_idx,
   output logic zero_span,
   output logic span_led,
   output logic [7:0] ref_level,
   output logic fine_step
);
   function automatic logic is_letter(input logic [7:0] c);
      return (c >= 8'h41) && (c <= 8'h5A);
   endfunction

   function automatic logic [31:0] span_khz(input logic [3:0] i);
      case (i)
         4'h0: span_khz = 32'h00000032;
         4'h1: span_khz = 32'h00000064;
         4'h2: span_khz = 32'h000000C8;
         4'h3: span_khz = 32'h000001F4;
         4'h4: span_khz = 32'h000003E8;
         4'h5: span_khz = 32'h000007D0;
         4'h6: span_khz = 32'h00001388;
         4'h7: span_khz = 32'h00002710;
         4'h8: span_khz = 32'h00004E20;
         4'h9: span_khz = 32'h0000C350;
         4'hA: span_khz = 32'h000186A0;
         4'hB: span_khz = 32'h00030D40;
         4'hC: span_khz = 32'h0007A120;
         4'hD: span_khz = 32'h000F4240;
         4'hE: span_khz = 32'h001E8480;
         default: span_khz = 32'h003D0900;
      endcase
   endfunction

   span_ref_pkg::parse_st_t p_st_q;
   span_ref_pkg::emit_st_t e_st_q;
   span_ref_pkg::reply_kind_t kind_q;
   logic [7:0] first_q;
   logic op_q;
   logic [15:0] num_q;
   logic [31:0] mult_q;
   logic [4:0] sw_s1_q;
   logic [4:0] sw_s2_q;
   logic [4:0] addr_q;
   logic [3:0] span_idx_q;
   logic zero_q;
   logic led_q;
   logic signed [7:0] level_q;
   logic fine_q;
   logic rx_ready_q;
   logic [7:0] tx_byte_q;
   logic tx_valid_q;
   logic tx_last_q;
   logic [3:0] e_pos_q;
   logic lz_q;
   logic neg_q;
   logic conv_start_q;
   logic [31:0] conv_val_q;
   logic conv_done;
   logic [39:0] bcd;

   // byte decode
   wire take = rx_valid && rx_ready_q;
   wire letter = is_letter(rx_byte);
   wire digit = (rx_byte >= 8'h30) && (rx_byte <= 8'h39);
   wire [15:0] pair = {first_q, rx_byte};
   wire pair_ok = take && (p_st_q == span_ref_pkg::P_SECOND) && letter;
   wire cmd_plain = pair_ok && !op_q;
   // letter pairs compared as their two ascii codes
   wire c_narrow = cmd_plain && (pair == 16'h4E52);
   wire c_widen = cmd_plain && (pair == 16'h5744);
   wire c_span = cmd_plain && (pair == 16'h5350);
   wire c_zero = cmd_plain && (pair == 16'h5A53);
   wire c_up = cmd_plain && (pair == 16'h4C55);
   wire c_down = cmd_plain && (pair == 16'h4C44);
   wire c_tog = cmd_plain && (pair == 16'h4643);
   wire c_mode = cmd_plain && (pair == 16'h4F4D);
   wire c_op = cmd_plain && (pair == 16'h4F50);
   wire q_span = pair_ok && op_q && (pair == 16'h5350);
   wire q_level = pair_ok && op_q && (pair == 16'h524C);
   wire c_unit_end = take && (p_st_q == span_ref_pkg::P_UNIT) && (rx_byte == "Z");

   // direct span value match against the coded set
   wire [31:0] want_khz = 32'(num_q) * mult_q;
   logic set_hit;
   logic [3:0] set_idx;
   always_comb begin
      set_hit = 1'b0;
      set_idx = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (span_khz(4'(i)) == want_khz) begin
            set_hit = 1'b1;
            set_idx = 4'(i);
         end
      end
   end

   // level limits; the usable window slides up with attenuation and is capped
   wire signed [8:0] up_raw = $signed(`RL_UP_BASE) + $signed({3'b000, atten_db});
   wire signed [8:0] up_lim = (up_raw > $signed(`RL_UP_CAP)) ? $signed(`RL_UP_CAP) : up_raw;
   wire signed [8:0] lo_lim = $signed(`RL_LO_BASE) + $signed({3'b000, atten_db});
   wire signed [8:0] lvl9 = 9'(level_q);
   wire signed [8:0] step9 = fine_q ? 9'(`RL_STEP_FINE) : 9'(`RL_STEP_COARSE);
   wire signed [8:0] lvl_up = lvl9 + step9;
   wire signed [8:0] lvl_dn = lvl9 - step9;

   // reply byte selection
   wire [5:0] dsh = {e_pos_q == `POS_SIGN ? 4'h0 : `POS_LAST_DIGIT - e_pos_q, 2'b00};
   wire [3:0] dig = 4'(bcd >> dsh);
   wire pos_digit = (e_pos_q != `POS_SIGN) && (e_pos_q <= `POS_LAST_DIGIT);
   wire num_skip = (e_pos_q == `POS_SIGN) ? !neg_q :
                   pos_digit && lz_q && (dig == 4'h0) && (e_pos_q != `POS_LAST_DIGIT);
   wire [7:0] num_byte = (e_pos_q == `POS_SIGN) ? `CH_MINUS :
                         pos_digit ? (`CH_ZERO | {4'h0, dig}) :
                         (e_pos_q == `POS_CR) ? `CH_CR : `CH_LF;
   wire [7:0] mode_byte = (e_pos_q == 4'h0) ? {4'h0, span_idx_q} :
                          (e_pos_q == 4'h1) ? {7'h00, zero_q} :
                          (e_pos_q == 4'h2) ? {7'h00, led_q} :
                          (e_pos_q == 4'h3) ? {7'h00, fine_q} : `MODE_FILL;
   wire is_mode = (kind_q == span_ref_pkg::REP_MODE);
   wire e_skip = !is_mode && num_skip;
   wire [7:0] e_byte = is_mode ? mode_byte : num_byte;
   wire e_last = is_mode ? (e_pos_q == `POS_MODE_LAST) : (e_pos_q == `POS_LF);
   wire slot_free = !tx_valid_q || tx_ready;
   wire launch = q_span || q_level || c_mode;

   bin_to_dec bin_to_dec_inst (
      .mclk(mclk),
      .srst(srst),
      .start(conv_start_q),
      .bin(conv_val_q),
      .done(conv_done),
      .bcd(bcd)
   );

   // switch is a pin: two stages, captured while reset is held
   always_ff @(posedge mclk) begin
      sw_s1_q <= addr_switch;
      sw_s2_q <= sw_s1_q;
      if (srst) begin
         addr_q <= (sw_s2_q > `ADDR_MAX) ? `ADDR_MAX : sw_s2_q;
      end
   end

   // parser
   always_ff @(posedge mclk) begin
      if (srst) begin
         p_st_q <= span_ref_pkg::P_IDLE;
         first_q <= 8'h00;
         op_q <= 1'b0;
         num_q <= 16'h0000;
         mult_q <= `MULT_K;
      end else if (take) begin
         p_st_q <= span_ref_pkg::P_IDLE;
         case (p_st_q)
            span_ref_pkg::P_IDLE: begin
               if (letter) begin
                  first_q <= rx_byte;
                  p_st_q <= span_ref_pkg::P_SECOND;
               end
            end
            span_ref_pkg::P_SECOND: begin
               op_q <= c_op;
               if (c_span) begin
                  num_q <= 16'h0000;
                  p_st_q <= span_ref_pkg::P_NUM;
               end else if (c_op) begin
                  p_st_q <= span_ref_pkg::P_IDLE;
               end
            end
            span_ref_pkg::P_NUM: begin
               if (digit) begin
                  // saturate well above any coded mantissa
                  if (num_q < 16'h1000) begin
                     num_q <= 16'(num_q * 16'h000A) + {12'h000, rx_byte[3:0]};
                  end
                  p_st_q <= span_ref_pkg::P_NUM;
               end else if (rx_byte == `CH_SPACE && num_q == 16'h0000) begin
                  p_st_q <= span_ref_pkg::P_NUM;
               end else if (rx_byte == "K" || rx_byte == "M" || rx_byte == "G") begin
                  mult_q <= (rx_byte == "K") ? `MULT_K : (rx_byte == "M") ? `MULT_M : `MULT_G;
                  p_st_q <= span_ref_pkg::P_UNIT;
               end else if (letter) begin
                  first_q <= rx_byte;
                  p_st_q <= span_ref_pkg::P_SECOND;
               end
            end
            default: begin
               p_st_q <= span_ref_pkg::P_IDLE;
            end
         endcase
      end
   end

   // settings
   always_ff @(posedge mclk) begin
      if (srst) begin
         span_idx_q <= `SPAN_IDX_RST;
         zero_q <= 1'b0;
         led_q <= 1'b0;
         level_q <= `RL_RST;
         fine_q <= 1'b0;
      end else begin
         if (c_narrow) begin
            zero_q <= 1'b0;
            if (span_idx_q != 4'h0) begin
               span_idx_q <= span_idx_q - 4'h1;
            end
         end else if (c_widen) begin
            zero_q <= 1'b0;
            if (span_idx_q != `SPAN_IDX_MAX) begin
               span_idx_q <= span_idx_q + 4'h1;
            end
         end else if (c_zero) begin
            zero_q <= 1'b1;
         end else if (c_unit_end && set_hit && num_q != 16'h0000) begin
            span_idx_q <= set_idx;
            zero_q <= 1'b0;
         end
         if (c_span || q_span || c_narrow || c_widen || c_zero) begin
            led_q <= 1'b1;
         end else if (c_up || c_down || c_tog || q_level) begin
            led_q <= 1'b0;
         end
         if (c_tog) begin
            fine_q <= !fine_q;
         end
         // steps that would leave the window are refused, not clipped
         if (c_up && lvl_up <= up_lim) begin
            level_q <= 8'(lvl_up);
         end else if (c_down && lvl_dn >= lo_lim) begin
            level_q <= 8'(lvl_dn);
         end else if (lvl9 > up_lim) begin
            level_q <= 8'(up_lim);
         end else if (lvl9 < lo_lim) begin
            level_q <= 8'(lo_lim);
         end
      end
   end

   // replies; the listener stalls until the reply is fully taken
   always_ff @(posedge mclk) begin
      if (srst) begin
         e_st_q <= span_ref_pkg::E_IDLE;
         kind_q <= span_ref_pkg::REP_NUM;
         rx_ready_q <= 1'b0;
         tx_byte_q <= 8'h00;
         tx_valid_q <= 1'b0;
         tx_last_q <= 1'b0;
         e_pos_q <= 4'h0;
         lz_q <= 1'b1;
         neg_q <= 1'b0;
         conv_start_q <= 1'b0;
         conv_val_q <= 32'h00000000;
      end else begin
         conv_start_q <= 1'b0;
         case (e_st_q)
            span_ref_pkg::E_IDLE: begin
               rx_ready_q <= !launch;
               e_pos_q <= 4'h0;
               lz_q <= 1'b1;
               if (q_span) begin
                  kind_q <= span_ref_pkg::REP_NUM;
                  neg_q <= 1'b0;
                  conv_val_q <= zero_q ? 32'h00000000 : span_khz(span_idx_q) * `HZ_PER_KHZ;
                  conv_start_q <= 1'b1;
                  e_st_q <= span_ref_pkg::E_CONV;
               end else if (q_level) begin
                  kind_q <= span_ref_pkg::REP_NUM;
                  neg_q <= level_q[7];
                  conv_val_q <= {24'h000000, level_q[7] ? 8'(-level_q) : level_q};
                  conv_start_q <= 1'b1;
                  e_st_q <= span_ref_pkg::E_CONV;
               end else if (c_mode) begin
                  kind_q <= span_ref_pkg::REP_MODE;
                  e_st_q <= span_ref_pkg::E_SEND;
               end
            end
            span_ref_pkg::E_CONV: begin
               if (conv_done) begin
                  e_st_q <= span_ref_pkg::E_SEND;
               end
            end
            span_ref_pkg::E_SEND: begin
               if (slot_free) begin
                  tx_valid_q <= !e_skip;
                  tx_byte_q <= e_byte;
                  tx_last_q <= e_last;
                  e_pos_q <= e_pos_q + 4'h1;
                  if (pos_digit && dig != 4'h0) begin
                     lz_q <= 1'b0;
                  end
                  if (e_last) begin
                     e_st_q <= span_ref_pkg::E_DRAIN;
                  end
               end
            end
            default: begin
               if (tx_ready) begin
                  tx_valid_q <= 1'b0;
                  tx_last_q <= 1'b0;
                  rx_ready_q <= 1'b1;
                  e_st_q <= span_ref_pkg::E_IDLE;
               end
            end
         endcase
      end
   end

   assign rx_ready = rx_ready_q;
   assign tx_byte = tx_byte_q;
   assign tx_valid = tx_valid_q;
   assign tx_last = tx_last_q;
   assign bus_addr = addr_q;
   assign span_idx = span_idx_q;
   assign zero_span = zero_q;
   assign span_led = led_q;
   assign ref_level = level_q;
   assign fine_step = fine_q;
endmodule
`default_nettype wire

// [src/span_ref_pkg.sv]
// types shared by the span and reference level command handler
`default_nettype none
package span_ref_pkg;
   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_SECOND = 2'b01,
      P_NUM = 2'b10,
      P_UNIT = 2'b11
   } parse_st_t;
   typedef enum logic [1:0] {
      E_IDLE = 2'b00,
      E_CONV = 2'b01,
      E_SEND = 2'b10,
      E_DRAIN = 2'b11
   } emit_st_t;
   typedef enum logic {
      REP_NUM = 1'b0,
      REP_MODE = 1'b1
   } reply_kind_t;
endpackage
`default_nettype wire

// [src/span_ref_regs.svh]
// constants for the span and reference level command handler
//
// Summary of operation
// - narrow step lowers span one 1-2-5 position, widen step raises it one.
// - span query returns span in hertz, selects span function, lights its indicator.
// - direct span accepts only coded values 50 kHz..4 GHz, or zero span code.
// - reference level takes step up, step down and coarse/fine toggle commands.
// - level down lowers one step of current size, level up raises one step.
// - allowed level range slides up with attenuator, top capped at 20 dBm; out-of-range levels refused.
// - mode string query sends numeric elements describing current settings.
// - mode string element four reports level step: 0 coarse, 1 fine.
// - level query returns current reference level in dBm.
// - listener/talker address comes from five-bit binary switch, 0 to 30.
`ifndef SPAN_REF_REGS_SVH
`define SPAN_REF_REGS_SVH

`define SPAN_IDX_RST 4'hF
`define SPAN_IDX_MAX 4'hF
`define RL_RST 8'hF6
`define RL_STEP_COARSE 8'h0A
`define RL_STEP_FINE 8'h01
`define RL_UP_BASE 9'h1F6
`define RL_UP_CAP 9'h014
`define RL_LO_BASE 9'h192
`define ADDR_MAX 5'h1E
`define MODE_FILL 8'h00
`define CH_MINUS 8'h2D
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_ZERO 8'h30
`define CH_SPACE 8'h20
`define MULT_K 32'h00000001
`define MULT_M 32'h000003E8
`define MULT_G 32'h000F4240
`define HZ_PER_KHZ 32'h000003E8
`define CONV_BITS 6'h20
`define POS_SIGN 4'h0
`define POS_LAST_DIGIT 4'hA
`define POS_CR 4'hB
`define POS_LF 4'hC
`define POS_MODE_LAST 4'h6

`endif

// [tb/ctl_model.sv]
// controller model: feeds command bytes and takes reply bytes
`default_nettype none
module ctl_model (
   input wire logic mclk,
   input wire logic rx_ready,
   input wire logic slow,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_q = 2'h0;
   initial begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // slow mode takes one reply byte in four to stretch the talker hold
   always @(negedge mclk) begin
      cnt_q <= cnt_q + 2'h1;
      tx_ready <= !slow || cnt_q == 2'h3;
   end
   // the line is released between strings so two commands never touch
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge mclk);
         rx_byte <= s[i];
         rx_valid <= 1'b1;
         do @(posedge mclk); while (rx_ready !== 1'b1);
      end
      @(negedge mclk);
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask
endmodule
`default_nettype wire

// [tb/span_ref_chk.sv]
// port assertions for the span and reference level command handler
`default_nettype none
module span_ref_chk (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_last,
   input wire logic tx_ready,
   input wire logic [5:0] atten_db,
   input wire logic [4:0] bus_addr,
   input wire logic [3:0] span_idx,
   input wire logic zero_span,
   input wire logic span_led,
   input wire logic [7:0] ref_level,
   input wire logic fine_step
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // level window is worked out here so a step is judged against the atten in force
   wire logic signed [9:0] lvl = {{2{ref_level[7]}}, ref_level};
   wire logic signed [9:0] att = {4'h0, atten_db};
   wire logic signed [9:0] stp = fine_step ? 10'sh001 : 10'sh00A;
   wire logic signed [9:0] top = (atten_db > 6'h1E) ? 10'sh014 : att - 10'sh00A;
   wire logic [7:0] up_val = (lvl + stp <= top) ? ref_level + stp[7:0] : ref_level;
   wire logic [7:0] dn_val = (lvl - stp >= att - 10'sh06E) ? ref_level - stp[7:0] : ref_level;
   sequence s_tk(logic [7:0] c);
      rx_valid && rx_ready && rx_byte == c;
   endsequence
   sequence s_pair(logic [7:0] a, logic [7:0] b);
      s_tk(a) ##1 s_tk(b);
   endsequence
   chk_narrow_step: assert property (s_pair(8'h4E, 8'h52) |=> span_led && !zero_span
      && span_idx == (($past(span_idx) == 4'h0) ? 4'h0 : $past(span_idx) - 4'h1))
      else $error("narrow step gave wrong span");
   chk_widen_step: assert property (s_pair(8'h57, 8'h44) |=> span_led && !zero_span
      && span_idx == (($past(span_idx) == 4'hF) ? 4'hF : $past(span_idx) + 4'h1))
      else $error("widen step gave wrong span");
   chk_level_up: assert property (s_pair(8'h4C, 8'h55) |=> ref_level == $past(up_val))
      else $error("level up gave wrong level");
   chk_level_down: assert property (s_pair(8'h4C, 8'h44) |=> ref_level == $past(dn_val))
      else $error("level down gave wrong level");
   chk_step_toggle: assert property (s_pair(8'h46, 8'h43) |=> fine_step != $past(fine_step))
      else $error("step size did not toggle");
   chk_span_query: assert property (s_pair(8'h4F, 8'h50) ##1 s_pair(8'h53, 8'h50)
      |=> span_led && !rx_ready) else $error("span query did not select span");
   chk_mode_start: assert property (s_pair(8'h4F, 8'h4D)
      |=> !rx_ready ##1 (tx_valid && tx_byte == {4'h0, span_idx}))
      else $error("mode reply did not start");
   chk_query_refuse: assert property (s_pair(8'h52, 8'h4C)
      |=> !rx_ready [*3] ##[1:60] tx_valid) else $error("level query reply missing");
   chk_reply_holds: assert property (tx_valid && !tx_ready
      |=> tx_valid && $stable(tx_byte) && $stable(tx_last)) else $error("reply byte dropped");
   chk_addr_range: assert property (bus_addr <= 5'h1E) else $error("address above 30");
   chk_addr_stable: assert property (!$past(srst) |-> $stable(bus_addr))
      else $error("address moved outside reset");
endmodule
`default_nettype wire

// [tb/test_span_and_ref_level_cmd_handler.sv]
// self-checking bench for the span and reference level command handler
`default_nettype none
module test_span_and_ref_level_cmd_handler;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic slow = 1'b0;
   logic [4:0] addr_switch = 5'h1F;
   logic [5:0] atten_db = 6'h0A;
   wire logic [7:0] rx_byte, tx_byte, ref_level;
   wire logic rx_valid, rx_ready, tx_valid, tx_last, tx_ready, zero_span, span_led, fine_step;
   wire logic [4:0] bus_addr;
   wire logic [3:0] span_idx;
   int num_errors = 0;
   int samples_checked = 0;
   int lvl = -10;
   int att = 10;
   bit fine = 1'b0;
   logic [7:0] rnd = 8'h2C;
   logic [4:0] ea;
   logic [8:0] exp_q[$];
   logic [7:0] mode_exp[7] = '{8'h0C, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
   span_and_ref_level_cmd_handler span_and_ref_level_cmd_handler_inst (.mclk, .srst,
      .addr_switch, .rx_byte, .rx_valid, .rx_ready, .tx_byte, .tx_valid, .tx_last,
      .tx_ready, .atten_db, .bus_addr, .span_idx, .zero_span, .span_led, .ref_level,
      .fine_step);
   ctl_model ctl_model_inst (.mclk, .rx_ready, .slow, .rx_byte, .rx_valid, .tx_ready);
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic longint span_hz(input int i);
      longint m;
      if (i == 15) return 64'hEE6B2800;
      m = (i % 3 == 0) ? 64'h5 : (i % 3 == 1) ? 64'h1 : 64'h2;
      repeat ((i + 2) / 3 + 4) m = m * 64'hA;
      return m;
   endfunction
   function automatic string code(input int i);
      longint h;
      h = span_hz(i);
      if (h >= 64'h3B9ACA00) return $sformatf("%s%0dGZ", 16'h5350, h / 64'h3B9ACA00);
      if (h >= 64'hF4240) return $sformatf("%s%0dMZ", 16'h5350, h / 64'hF4240);
      return $sformatf("%s%0dKZ", 16'h5350, h / 64'h3E8);
   endfunction
   function automatic int hi();
      return (att > 30) ? 20 : att - 10;
   endfunction
   task automatic cmp_set(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_tx(input logic [8:0] got, input logic [8:0] exp);
      cmp_set(got, exp, "reply byte");
   endtask
   task automatic cmd(input string s);
      ctl_model_inst.send(s);
      @(negedge mclk);
   endtask
   // a number reply is decimal with a minus sign when negative, then CR and LF
   task automatic expect_num(input longint v);
      string s;
      s = $sformatf("%0d", v);
      for (int i = 0; i < s.len(); i++) exp_q.push_back({1'b0, s[i]});
      exp_q.push_back(9'h00D);
      exp_q.push_back(9'h10A);
   endtask
   task automatic wait_reply();
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(negedge mclk);
      cmp_set(exp_q.size(), 32'h0, "reply length");
   endtask
   task automatic query(input string s, input longint v);
      expect_num(v);
      cmd(s);
      wait_reply();
   endtask
   task automatic toggle();
      fine = !fine;
      cmd(string'(16'h4643));
      cmp_set(fine_step, fine, "step size");
   endtask
   task automatic lvl_cmd(input bit up);
      int n;
      n = up ? lvl + (fine ? 1 : 10) : lvl - (fine ? 1 : 10);
      if (n <= hi() && n >= att - 110) lvl = n;
      cmd(string'(up ? 16'h4C55 : 16'h4C44));
      cmp_set(ref_level, lvl[7:0], "level step");
   endtask
   // moving the attenuator may pull the level back inside the shifted window
   task automatic set_att(input int v);
      att = v;
      atten_db <= v[5:0];
      if (lvl > hi()) lvl = hi();
      if (lvl < att - 110) lvl = att - 110;
      repeat (3) @(negedge mclk);
      cmp_set(ref_level, lvl[7:0], "level clamp");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (exp_q.size() == 0) cmp_tx({tx_last, tx_byte}, 9'h1FF);
         else cmp_tx({tx_last, tx_byte}, exp_q.pop_front());
      end
   end
   initial begin
      repeat (40000) @(posedge mclk);
      num_errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      give_verdict();
   end
   initial begin
      repeat (8) @(negedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      cmp_set(bus_addr, 5'h1E, "address");
      cmp_set({span_idx, zero_span, span_led, fine_step, ref_level}, 15'h78F6, "reset");
      for (int i = 14; i >= -1; i--) begin
         cmd(string'(16'h4E52));
         cmp_set(span_idx, (i < 0) ? 4'h0 : i[3:0], "narrow");
      end
      for (int i = 1; i <= 16; i++) begin
         cmd(string'(16'h5744));
         cmp_set(span_idx, (i > 15) ? 4'hF : i[3:0], "widen");
      end
      slow <= 1'b1;
      query(string'(32'h4F505350), span_hz(15));
      $display("span step test done");
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         slow <= rnd[1];
         cmd(code(i));
         cmp_set(span_idx, i[3:0], "direct span");
         query(string'(32'h4F505350), span_hz(i));
      end
      cmd(string'({16'h5350, "30MZ"}));
      cmp_set(span_idx, 4'hF, "uncoded span");
      cmd(string'({16'h5350, " 1GZ"}));
      cmp_set(span_idx, 4'hD, "spaced span");
      cmd(string'(16'h5A53));
      cmp_set(zero_span, 1'b1, "zero span");
      query(string'(32'h4F505350), 0);
      cmd(string'(16'h4E52));
      cmp_set({zero_span, span_led}, 2'h1, "leave zero span");
      cmd(string'({16'h5350, "500MZ"}));
      $display("direct span test done");
      toggle();
      cmp_set(span_led, 1'b0, "span indicator");
      foreach (mode_exp[i]) exp_q.push_back({i == 6, mode_exp[i]});
      cmd(string'(16'h4F4D));
      wait_reply();
      lvl_cmd(1'b1);
      lvl_cmd(1'b0);
      toggle();
      lvl_cmd(1'b1);
      lvl_cmd(1'b1);
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         if (rnd[7]) set_att(rnd[5:0]);
         if (rnd[6]) toggle();
         lvl_cmd(rnd[0]);
      end
      query(string'(32'h4F50524C), lvl);
      $display("level test done");
      rnd = lfsr(rnd);
      ea = (rnd[4:0] == 5'h1F) ? 5'h1E : rnd[4:0];
      addr_switch <= rnd[4:0];
      srst <= 1'b1;
      repeat (8) @(negedge mclk);
      srst <= 1'b0;
      addr_switch <= ~rnd[4:0];
      repeat (6) @(negedge mclk);
      cmp_set(bus_addr, ea, "address");
      $display("address test done");
      give_verdict();
   end
endmodule
bind span_and_ref_level_cmd_handler span_ref_chk span_ref_chk_inst (.mclk, .srst, .rx_byte,
   .rx_valid, .rx_ready, .tx_byte, .tx_valid, .tx_last, .tx_ready, .atten_db, .bus_addr,
   .span_idx, .zero_span, .span_led, .ref_level, .fine_step);
`default_nettype wire
